// ==== src/cprs_processor.sv ====
// cprs_processor: processor-side reset behaviour
// Operation
// - power-ok low and clean until stable
// - power-ok may drop; rise followed by reset
// - power-on reset held at least 1 ms
// - reset clears state and invalidates caches
// - bus outputs released within two clocks
// - straps latched at reset release
// - strap bit 0 low disables interrupt unit
// - optional self-test then fetch reset vector
// - init strap active runs self-test, unless tristate strap also set
// assumes link inputs come from another domain and are synchronised
`timescale 1ns/10ps
`default_nettype none

// cprs_sync2: two-flop synchroniser, frozen while clk_en is low
module cprs_sync2
  import cprs_pkg::*;
#(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] INIT = '0
)(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  // first stage feeds only the second, never other logic
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      meta_q <= INIT;
      sync_q <= INIT;
    end
    else if (clk_en)
    begin
      meta_q <= d_in;
      sync_q <= meta_q;
    end
  end
  assign q_out = sync_q;
endmodule // cprs_sync2

module cprs_processor
  import cprs_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  cprs_link_if.processor link,
  output logic cache_invalid,
  output logic local_interrupt_unit_en,
  output logic bist_running,
  output logic fetch_valid,
  output logic [31:0] fetch_addr
);
  typedef enum {ST_RESET, ST_BIST, ST_FETCH, ST_RUN, ST_FLOAT} cprs_state_type;
  cprs_state_type st_q;
  cprs_state_type st_d;
  logic rst_seen_n;
  logic pok_seen;
  logic dat_seen;
  logic [STRAP_W-1:0] strap_seen;
  logic r_prev_q;
  logic [1:0] rel_q;
  logic drv_q;
  logic inv_q;
  logic irq_en_q;
  logic bist_q;
  logic fv_q;
  logic [31:0] fa_q;
  logic [7:0] bc_q;
  // reset as seen here, its release edge and the sampled straps
  wire logic in_rst = !rst_seen_n || !pok_seen;
  wire logic rel_edge = r_prev_q && !in_rst;
  wire logic [STRAP_W-1:0] smp = {strap_seen[STRAP_W-1:1], dat_seen};
  // strap decode, acted on only at the release edge
  wire logic boot_now = (st_q == ST_RESET) && rel_edge;
  wire logic go_float = boot_now && smp[STRAP_TRISTATE_BIT];
  wire logic go_bist = boot_now && !smp[STRAP_TRISTATE_BIT] && smp[STRAP_INIT_BIT];
  wire logic [31:0] vec_sel = smp[STRAP_VECTOR_BIT] ? RESET_VECTOR_HIGH : RESET_VECTOR_LOW;
  // state decode outside reset, and counter end points
  wire logic in_bist = !in_rst && (st_q == ST_BIST);
  wire logic in_fetch = !in_rst && (st_q == ST_FETCH);
  wire logic in_run = !in_rst && (st_q == ST_RUN);
  wire logic in_float = !in_rst && (st_q == ST_FLOAT);
  wire logic rel_done = (rel_q == 2'(BUS_RELEASE_CLOCKS - 1));
  wire logic bist_done = (bc_q == 8'(BIST_CYCLES - 1));
  // next values of the flags and the self-test counter
  wire logic drv_d = in_rst ? (drv_q && !rel_done) : (in_fetch || (drv_q && !in_float));
  wire logic inv_d = in_rst || (inv_q && !boot_now);
  wire logic fv_d = in_fetch || (fv_q && !in_rst && !in_run);
  wire logic bist_d = go_bist || (bist_q && !in_rst && !(in_bist && bist_done));
  wire logic [7:0] bc_d = go_bist ? 8'h00 : (in_bist ? bc_q + 8'h01 : bc_q);
  // link inputs come from the far end, two flops before any logic
  cprs_sync2 #(
    .W(1),
    .INIT(1'h0)
  ) u_cprs_sync2_rst (
    .clk(clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .d_in(link.sys_reset_n),
    .q_out(rst_seen_n)
  );
  cprs_sync2 #(
    .W(1),
    .INIT(1'h0)
  ) u_cprs_sync2_pok (
    .clk(clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .d_in(link.power_ok_indication),
    .q_out(pok_seen)
  );
  cprs_sync2 #(
    .W(1),
    .INIT(1'h1)
  ) u_cprs_sync2_dat (
    .clk(clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .d_in(link.irq_ctrl_serial_data),
    .q_out(dat_seen)
  );
  cprs_sync2 #(
    .W(STRAP_W),
    .INIT('0)
  ) u_cprs_sync2_strap (
    .clk(clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .d_in(link.strap),
    .q_out(strap_seen)
  );
  // next state of the boot sequence; reset seen overrides all
  always_comb
  begin
    st_d = st_q;
    case (st_q)
      ST_RESET:
      begin
        if (go_float)
          st_d = ST_FLOAT;
        else if (go_bist)
          st_d = ST_BIST;
        else if (boot_now)
          st_d = ST_FETCH;
      end
      ST_BIST:
      begin
        if (bist_done)
          st_d = ST_FETCH;
      end
      ST_FETCH: st_d = ST_RUN;
      ST_RUN: st_d = ST_RUN;
      ST_FLOAT: st_d = ST_FLOAT;
      default: st_d = ST_RESET;
    endcase
    if (in_rst)
      st_d = ST_RESET;
  end
  // boot state and release-edge tracker
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      st_q <= ST_RESET;
      r_prev_q <= 1'h1;
    end
    else if (clk_en)
    begin
      st_q <= st_d;
      r_prev_q <= in_rst;
    end
  end
  // bus release: count clocks of reset seen, then let go of the bus
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rel_q <= '0;
      drv_q <= 1'h0;
    end
    else if (clk_en)
    begin
      if (!in_rst)
        rel_q <= '0;
      else if (!rel_done)
        rel_q <= rel_q + 2'h1;
      drv_q <= drv_d;
    end
  end
  // cache, fetch and self-test flags
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      inv_q <= 1'h1;
      fv_q <= 1'h0;
      bist_q <= 1'h0;
      bc_q <= '0;
    end
    else if (clk_en)
    begin
      inv_q <= inv_d;
      fv_q <= fv_d;
      bist_q <= bist_d;
      bc_q <= bc_d;
    end
  end
  // configuration taken from the straps at the release edge
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      irq_en_q <= 1'h1;
      fa_q <= '0;
    end
    else if (clk_en && boot_now)
    begin
      irq_en_q <= smp[STRAP_IRQ_DIS_BIT];
      fa_q <= vec_sel;
    end
  end
  // outputs straight from the flops; serial data line never pulled here
  assign link.bus_drive_en = drv_q;
  assign link.irq_ctrl_serial_data_o = 1'h1;
  assign link.irq_ctrl_serial_data_oe = 1'h0;
  assign cache_invalid = inv_q;
  assign local_interrupt_unit_en = irq_en_q;
  assign bist_running = bist_q;
  assign fetch_valid = fv_q;
  assign fetch_addr = fa_q;
endmodule // cprs_processor
`default_nettype wire

// ==== src/cprs_pkg.sv ====
// cprs_pkg: shared constants for the processor power-on and reset sequencer
// assumes a single 100 MHz bus clock on both ends
package cprs_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned RESET_MIN_MS = 1;
  localparam int unsigned RESET_MIN_CYCLES =
    (RESET_MIN_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned BUS_RELEASE_CLOCKS = 2;
  localparam int unsigned BIST_CYCLES = 16;
  localparam int unsigned STRAP_W = 4;
  localparam int unsigned STRAP_IRQ_DIS_BIT = 0;
  localparam int unsigned STRAP_INIT_BIT = 1;
  localparam int unsigned STRAP_TRISTATE_BIT = 2;
  localparam logic [31:0] RESET_VECTOR_LOW = 32'h000FFFF0;
  localparam logic [31:0] RESET_VECTOR_HIGH = 32'hFFFFFFF0;
  localparam int unsigned STRAP_VECTOR_BIT = 3;
  localparam logic [STRAP_W-1:0] STRAP_DEFAULT = 4'h1;
  typedef enum logic [1:0] {CPRS_IRQ_DATA_W = 2} cprs_dummy_type;
endpackage

// ==== src/cprs_link_if.sv ====
// cprs_link_if: wires between reset sequencer and processor end
// assumes both ends share clk; open-drain strap line resolved here
`timescale 1ns/10ps
`default_nettype none
interface cprs_link_if;
  import cprs_pkg::*;
  logic power_ok_indication;
  logic sys_reset_n;
  logic [STRAP_W-1:0] strap;
  logic [STRAP_W-1:0] strap_oe;
  logic irq_ctrl_serial_data_o;
  logic irq_ctrl_serial_data_oe;
  logic bus_drive_en;
  wire irq_ctrl_serial_data;
  // open-drain serial data line, shared with strap bit 0, pulled high
  assign irq_ctrl_serial_data = (irq_ctrl_serial_data_oe && !irq_ctrl_serial_data_o) ||
                                (strap_oe[0] && !strap[0]) ? 1'b0 : 1'b1;
  modport sequencer (output power_ok_indication, output sys_reset_n, output strap,
                     output strap_oe, input bus_drive_en, input irq_ctrl_serial_data);
  modport processor (input power_ok_indication, input sys_reset_n, input strap,
                     input strap_oe, output irq_ctrl_serial_data_o,
                     output irq_ctrl_serial_data_oe, output bus_drive_en,
                     input irq_ctrl_serial_data);
endinterface
`default_nettype wire

// ==== src/cprs_sequencer.sv ====
// cprs_sequencer: system-side logic making power-ok and reset to the processor
// assumes supply_stable arrives from analogue monitors, synchronised here
`timescale 1ns/10ps
`default_nettype none
module cprs_sequencer
  import cprs_pkg::*;
#(
  parameter int unsigned RESET_CYCLES = RESET_MIN_CYCLES
)(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic supply_stable,
  input wire logic [STRAP_W-1:0] cfg_strap,
  cprs_link_if.sequencer link,
  output logic in_reset
);
  logic s1_q;
  logic s2_q;
  logic pok_q;
  logic rst_n_q;
  logic oe_q;
  logic in_reset_q;
  logic [STRAP_W-1:0] strap_q;
  logic [31:0] cnt_q;
  // timer end and the condition that forces reset
  wire logic cnt_done = (cnt_q >= RESET_CYCLES - 1);
  wire logic hold_reset = !s2_q || !pok_q;
  // two-flop synchroniser on the supply monitor
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s1_q <= 1'h0;
      s2_q <= 1'h0;
    end
    else if (clk_en)
    begin
      s1_q <= supply_stable;
      s2_q <= s1_q;
    end
  end
  // power-ok follows the synchronised monitor; strap levels driven
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pok_q <= 1'h0;
      strap_q <= STRAP_DEFAULT;
    end
    else if (clk_en)
    begin
      pok_q <= s2_q;
      strap_q <= cfg_strap;
    end
  end
  // reset timer, width counted only while power-ok is high
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rst_n_q <= 1'h0;
      in_reset_q <= 1'h1;
      cnt_q <= '0;
      oe_q <= 1'h1;
    end
    else if (clk_en)
    begin
      if (hold_reset)
      begin
        rst_n_q <= 1'h0;
        in_reset_q <= 1'h1;
        cnt_q <= '0;
        oe_q <= 1'h1;
      end
      else if (!rst_n_q)
      begin
        cnt_q <= cnt_q + 32'h1;
        if (cnt_done)
        begin
          rst_n_q <= 1'h1;
          in_reset_q <= 1'h0;
        end
      end
      else
        oe_q <= 1'h0; // straps held through the release edge
    end
  end
  // link outputs straight from the flops
  assign link.power_ok_indication = pok_q;
  assign link.sys_reset_n = rst_n_q;
  assign link.strap = strap_q;
  assign link.strap_oe = {STRAP_W{oe_q}};
  assign in_reset = in_reset_q;
endmodule // cprs_sequencer
`default_nettype wire

// ==== sim/cprs_link_sva.sv ====
// cprs_link_sva: timing checks on the link
// assumes one clock, sync active-low reset
`timescale 1ns/10ps
`default_nettype none
module cprs_link_sva
  import cprs_pkg::*;
#(parameter int unsigned RESET_CYCLES = RESET_MIN_CYCLES)(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic power_ok_indication,
  input wire logic sys_reset_n,
  input wire logic bus_drive_en
);
  int unsigned cnt_q;
  // reset cycles since power-ok rose
  always_ff @(posedge clk)
    cnt_q <= (!rst_n || !power_ok_indication) ? 0 : cnt_q + 32'(!sys_reset_n);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_reset_pok_low: assert property (!$past(power_ok_indication) |-> !sys_reset_n)
    else $error("reset free, power low");
  a_pok_rise_reset: assert property ($rose(power_ok_indication) |-> !sys_reset_n)
    else $error("power rose outside reset");
  a_reset_width: assert property ($rose(sys_reset_n) |-> cnt_q >= RESET_CYCLES)
    else $error("reset pulse short");
  a_bus_release: assert property ($fell(sys_reset_n) |-> ##[0:4] !bus_drive_en)
    else $error("bus kept in reset");
  a_bus_off_reset: assert property (!sys_reset_n [*5] |-> !bus_drive_en)
    else $error("bus driven in reset");
  a_drive_after_rel: assert property ($rose(bus_drive_en) |-> sys_reset_n)
    else $error("early bus drive");
  a_pok_fall: assert property ($fell(power_ok_indication) |-> ##[0:1] !sys_reset_n)
    else $error("no reset on power drop");
  a_release_pok: assert property ($rose(sys_reset_n) |-> power_ok_indication)
    else $error("release without power");
  c_release: cover property ($rose(sys_reset_n));
  c_drive: cover property ($rose(bus_drive_en));
  c_drop: cover property ($fell(power_ok_indication));
endmodule // cprs_link_sva
`default_nettype wire

// ==== sim/cpu_power_on_reset_sequence_tb.sv ====
// boots both ends under several strap sets
// assumes reset count shortened to 20
`timescale 1ns/10ps
`default_nettype none
module cpu_power_on_reset_sequence_tb;
  import cprs_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic supply_stable = 1'b0;
  logic clk_en = 1'b1;
  logic [STRAP_W-1:0] cfg_strap = STRAP_DEFAULT;
  logic [3:0] cases [4] = '{4'h1, 4'h8, 4'h3, 4'h5};
  logic in_reset, cache_invalid, irq_en, bist_running, fetch_valid;
  logic [31:0] fetch_addr;
  int n_errors = 0;
  int tests_run = 0;
  cprs_link_if link ();
  cprs_sequencer #(.RESET_CYCLES(20)) u_cprs_sequencer (.clk(clk), .rst_n(rst_n),
    .clk_en(clk_en), .supply_stable(supply_stable), .cfg_strap(cfg_strap), .link(link),
    .in_reset(in_reset));
  cprs_processor u_cprs_processor (.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .link(link),
    .cache_invalid(cache_invalid), .local_interrupt_unit_en(irq_en),
    .bist_running(bist_running), .fetch_valid(fetch_valid), .fetch_addr(fetch_addr));
  cprs_link_sva #(.RESET_CYCLES(20)) u_cprs_link_sva (.clk(clk), .rst_n(rst_n),
    .power_ok_indication(link.power_ok_indication), .sys_reset_n(link.sys_reset_n),
    .bus_drive_en(link.bus_drive_en));
  // 100 MHz clock
  always #5 clk = ~clk;
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // power up with straps s, check the boot, then drop power
  task automatic boot(input logic [3:0] s);
    logic seen_f = 1'b0;
    logic seen_b = 1'b0;
    @(posedge clk);
    supply_stable <= 1'b1;
    cfg_strap <= s;
    for (int i = 0; i < 200 && !seen_f; i++)
    begin
      @(posedge clk);
      #1;
      seen_b |= bist_running === 1'b1;
      seen_f = fetch_valid === 1'b1;
    end
    chk("fetch", !s[2], seen_f);
    chk("self_test", s[1], seen_b);
    chk("irq_en", s[0], irq_en);
    chk("strap_oe", 0, link.strap_oe);
    if (seen_f)
    begin
      chk("vector", s[3] ? RESET_VECTOR_HIGH : RESET_VECTOR_LOW, fetch_addr);
      chk("bus_drive", 1, link.bus_drive_en);
      chk("cache_inv", 0, cache_invalid);
    end
    @(posedge clk);
    supply_stable <= 1'b0;
    for (int i = 0; i < 12 && (cache_invalid !== 1'b1 || link.bus_drive_en !== 1'b0); i++)
    begin
      @(posedge clk);
      #1;
    end
    chk("in_reset", 1, in_reset);
    chk("cache_inv", 1, cache_invalid);
    chk("bus_drive", 0, link.bus_drive_en);
  endtask
  // reset, then one boot per strap set
  initial
  begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    chk("in_reset", 1, in_reset);
    chk("cache_inv", 1, cache_invalid);
    // supplies good but clock enable low: nothing may advance
    @(posedge clk);
    clk_en <= 1'b0;
    supply_stable <= 1'b1;
    repeat (30) @(posedge clk);
    #1;
    chk("frozen_pok", 0, link.power_ok_indication);
    chk("frozen_reset", 1, in_reset);
    @(posedge clk);
    supply_stable <= 1'b0;
    clk_en <= 1'b1;
    foreach (cases[k])
      boot(cases[k]);
    give_verdict();
  end
endmodule // cpu_power_on_reset_sequence_tb
`default_nettype wire
